// >>> src/adc_sequencer.sv
// converter sequencer with register file, result format and window check
`timescale 1ns/1ps
`default_nettype none
module adc_sequencer (
   input wire logic SYS_CLK,
   input wire logic RST,
   input wire logic [7:0] REG_ADDR,
   input wire logic REG_WR,
   input wire logic [7:0] REG_WDATA,
   input wire logic [7:0] REG_RD_ADDR,
   output logic [7:0] REG_RDATA,
   input wire logic START_PIN,
   input wire logic [9:0] SAR_RESULT,
   output logic ANALOG_POWER,
   output logic [2:0] CHANNEL,
   output logic SAMPLE,
   output logic CONVERT,
   output logic CONV_IRQ
);
   typedef enum logic [1:0] {
      IDLE = 2'b00,
      SAMPLING = 2'b01,
      CONVERTING = 2'b10
   } seq_state_t;

   seq_state_t state, next_state;
   logic [7:0] ctrl_one, next_ctrl_one;
   logic [7:0] ctrl_two, next_ctrl_two;
   logic [9:0] result, next_result;
   logic [7:0] upper_limit, next_upper_limit;
   logic [7:0] lower_limit, next_lower_limit;
   logic [2:0] chan_latch, next_chan_latch;
   logic [3:0] div_latch, next_div_latch;
   logic [3:0] phase, next_phase;
   logic pin_last, next_pin_last;
   logic [7:0] next_rdata;
   logic next_irq;
   logic tick;
   logic window_hit;
   logic running;
   logic start_req;
   logic finish;

   // --------------------------------
   // helper blocks
   // --------------------------------
   adc_prescaler u_prescaler (
      .clk(SYS_CLK),
      .rst(RST),
      .run(running),
      .divide(div_latch),
      .tick(tick)
   );

   adc_window_compare u_window (
      .result(SAR_RESULT),
      .upper_limit(upper_limit),
      .lower_limit(lower_limit),
      .outside(ctrl_one[adc_seq_pkg::BIT_OUTSIDE]),
      .hit(window_hit)
   );

   // formats the high byte from the stored result
   function automatic logic [7:0] high_byte(input logic [9:0] r, input logic fmt);
      high_byte = fmt ? {6'h00, r[9:8]} : r[9:2];
   endfunction

   // --------------------------------
   // sequencer and register next values
   // --------------------------------
   // the analog side is trusted to present a settled code on the final tick
   always_comb begin
      next_state = state;
      next_ctrl_one = ctrl_one;
      next_ctrl_two = ctrl_two;
      next_result = result;
      next_upper_limit = upper_limit;
      next_lower_limit = lower_limit;
      next_chan_latch = chan_latch;
      next_div_latch = div_latch;
      next_phase = phase;
      next_pin_last = START_PIN;
      running = (state != IDLE);
      finish = 1'b0;
      start_req = 1'b0;

      // plain register writes, done bit included; busy bit handled below
      if (REG_WR) begin
         case (REG_ADDR)
            adc_seq_pkg::ADDR_CONTROL_ONE: begin
               next_ctrl_one[6:0] = REG_WDATA[6:0];
               if (!ctrl_one[adc_seq_pkg::BIT_START_BUSY] && REG_WDATA[adc_seq_pkg::BIT_START_BUSY]) begin
                  start_req = 1'b1;
               end
            end
            adc_seq_pkg::ADDR_CONTROL_TWO: next_ctrl_two = REG_WDATA;
            adc_seq_pkg::ADDR_RESULT_HIGH: begin
               if (ctrl_two[adc_seq_pkg::BIT_HIGH_FORMAT]) begin
                  next_result[9:8] = REG_WDATA[1:0];
               end else begin
                  next_result[9:2] = REG_WDATA;
               end
            end
            adc_seq_pkg::ADDR_RESULT_LOW: next_result[7:0] = REG_WDATA;
            adc_seq_pkg::ADDR_WINDOW_UPPER: next_upper_limit = REG_WDATA;
            adc_seq_pkg::ADDR_WINDOW_LOWER: next_lower_limit = REG_WDATA;
            default: begin
            end
         endcase
      end

      // falling edge on the external start pin
      if (ctrl_one[adc_seq_pkg::BIT_PIN_TRIGGER] && pin_last && !START_PIN) begin
         start_req = 1'b1;
      end

      case (state)
         IDLE: begin
            if (start_req && ctrl_one[adc_seq_pkg::BIT_POWER]) begin
               next_state = SAMPLING;
               next_phase = 4'h0;
               next_ctrl_one[adc_seq_pkg::BIT_START_BUSY] = 1'b1;
               next_chan_latch = ctrl_two[adc_seq_pkg::CHAN_LSB +: 3];
               next_div_latch = ctrl_two[adc_seq_pkg::PRESCALE_LSB +: 4];
            end
         end
         SAMPLING: begin
            if (tick) begin
               next_phase = phase + 4'h1;
               if (phase == adc_seq_pkg::SAMPLE_CLOCKS - 4'h1) begin
                  next_state = CONVERTING;
                  next_phase = 4'h0;
               end
            end
         end
         CONVERTING: begin
            if (tick) begin
               next_phase = phase + 4'h1;
               // ten approximation clocks; the eleventh tick is the completion clock
               if (phase == adc_seq_pkg::CONVERT_CLOCKS) begin
                  finish = 1'b1;
               end
            end
         end
         default: next_state = IDLE;
      endcase

      // write of 0 to busy is ignored while running
      if (running) begin
         next_ctrl_one[adc_seq_pkg::BIT_START_BUSY] = 1'b1;
      end

      if (finish) begin
         next_result = SAR_RESULT;
         next_ctrl_one[adc_seq_pkg::BIT_CONV_DONE] = 1'b1;
         next_ctrl_one[adc_seq_pkg::BIT_RANGE_HIT] = window_hit;
         if (next_ctrl_one[adc_seq_pkg::BIT_REPEAT]) begin
            next_state = SAMPLING;
            next_phase = 4'h0;
            next_chan_latch = ctrl_two[adc_seq_pkg::CHAN_LSB +: 3];
            next_div_latch = ctrl_two[adc_seq_pkg::PRESCALE_LSB +: 4];
         end else begin
            next_state = IDLE;
            next_ctrl_one[adc_seq_pkg::BIT_START_BUSY] = 1'b0;
         end
      end

      // power removal wins over everything
      if (!next_ctrl_one[adc_seq_pkg::BIT_POWER]) begin
         next_state = IDLE;
         next_phase = 4'h0;
         next_ctrl_one[adc_seq_pkg::BIT_START_BUSY] = 1'b0;
      end
   end

   // --------------------------------
   // read mux and interrupt
   // --------------------------------
   // read data registered one cycle after the read address
   always_comb begin
      case (REG_RD_ADDR)
         adc_seq_pkg::ADDR_CONTROL_ONE: next_rdata = ctrl_one;
         adc_seq_pkg::ADDR_CONTROL_TWO: next_rdata = ctrl_two;
         adc_seq_pkg::ADDR_RESULT_HIGH: next_rdata = high_byte(result, ctrl_two[adc_seq_pkg::BIT_HIGH_FORMAT]);
         adc_seq_pkg::ADDR_RESULT_LOW: next_rdata = result[7:0];
         adc_seq_pkg::ADDR_WINDOW_UPPER: next_rdata = upper_limit;
         adc_seq_pkg::ADDR_WINDOW_LOWER: next_rdata = lower_limit;
         default: next_rdata = 8'h00;
      endcase
      if (next_ctrl_one[adc_seq_pkg::BIT_RANGE_GATE]) begin
         next_irq = next_ctrl_one[adc_seq_pkg::BIT_CONV_DONE] & next_ctrl_one[adc_seq_pkg::BIT_RANGE_HIT];
      end else begin
         next_irq = next_ctrl_one[adc_seq_pkg::BIT_CONV_DONE];
      end
   end

   // --------------------------------
   // state registers
   // --------------------------------
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         state <= IDLE;
         ctrl_one <= adc_seq_pkg::REG_RESET;
         ctrl_two <= adc_seq_pkg::REG_RESET;
         result <= 10'h000;
         upper_limit <= adc_seq_pkg::REG_RESET;
         lower_limit <= adc_seq_pkg::REG_RESET;
         chan_latch <= 3'h0;
         div_latch <= 4'h0;
         phase <= 4'h0;
         pin_last <= 1'b1;
         REG_RDATA <= 8'h00;
         ANALOG_POWER <= 1'b0;
         CHANNEL <= 3'h0;
         SAMPLE <= 1'b0;
         CONVERT <= 1'b0;
         CONV_IRQ <= 1'b0;
      end else begin
         state <= next_state;
         ctrl_one <= next_ctrl_one;
         ctrl_two <= next_ctrl_two;
         result <= next_result;
         upper_limit <= next_upper_limit;
         lower_limit <= next_lower_limit;
         chan_latch <= next_chan_latch;
         div_latch <= next_div_latch;
         phase <= next_phase;
         pin_last <= next_pin_last;
         REG_RDATA <= next_rdata;
         ANALOG_POWER <= next_ctrl_one[adc_seq_pkg::BIT_POWER];
         CHANNEL <= next_chan_latch;
         SAMPLE <= (next_state == SAMPLING);
         CONVERT <= (next_state == CONVERTING);
         CONV_IRQ <= next_irq;
      end
   end
endmodule
`default_nettype wire

// >>> pkg/adc_seq_pkg.sv
// constants for the converter sequencer and window comparator
package adc_seq_pkg;
   // ----------------------------------------
   // register addresses
   // ----------------------------------------
   localparam logic [7:0] ADDR_CONTROL_ONE = 8'hb2;
   localparam logic [7:0] ADDR_CONTROL_TWO = 8'hb3;
   localparam logic [7:0] ADDR_RESULT_HIGH = 8'hb4;
   localparam logic [7:0] ADDR_RESULT_LOW = 8'hb5;
   localparam logic [7:0] ADDR_WINDOW_UPPER = 8'hb6;
   localparam logic [7:0] ADDR_WINDOW_LOWER = 8'hb7;
   localparam logic [7:0] REG_RESET = 8'h00;
   // ----------------------------------------
   // control one bit positions
   // ----------------------------------------
   localparam int BIT_START_BUSY = 7;
   localparam int BIT_CONV_DONE = 6;
   localparam int BIT_REPEAT = 5;
   localparam int BIT_PIN_TRIGGER = 4;
   localparam int BIT_RANGE_GATE = 3;
   localparam int BIT_RANGE_HIT = 2;
   localparam int BIT_POWER = 1;
   localparam int BIT_OUTSIDE = 0;
   // ----------------------------------------
   // control two fields
   // ----------------------------------------
   localparam int BIT_HIGH_FORMAT = 7;
   localparam int CHAN_LSB = 4;
   localparam int PRESCALE_LSB = 0;
   // ----------------------------------------
   // conversion timing in converter clocks
   // ----------------------------------------
   localparam logic [3:0] SAMPLE_CLOCKS = 4'h5;
   localparam logic [3:0] CONVERT_CLOCKS = 4'ha;
   localparam logic [4:0] TOTAL_CLOCKS = 5'h10;
endpackage

// >>> src/adc_prescaler.sv
// converter clock tick generator dividing the machine clock by n+1
`timescale 1ns/1ps
`default_nettype none
module adc_prescaler (
   input wire logic clk,
   input wire logic rst,
   input wire logic run,
   input wire logic [3:0] divide,
   output logic tick
);
   logic [3:0] count;
   logic [3:0] next_count;
   logic next_tick;

   // --------------------------------
   // divide counter
   // --------------------------------
   // counter restarts when the sequencer leaves idle, not between repeat conversions; the registered tick adds one cycle before the first
   // >= so that a smaller divide latched in repeat mode cannot let the count run past it
   always_comb begin
      next_count = count;
      next_tick = 1'b0;
      if (!run) begin
         next_count = 4'h0;
      end else if (count >= divide) begin
         next_count = 4'h0;
         next_tick = 1'b1;
      end else begin
         next_count = count + 4'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         count <= 4'h0;
         tick <= 1'b0;
      end else begin
         count <= next_count;
         tick <= next_tick;
      end
   end
endmodule
`default_nettype wire

// >>> src/adc_window_compare.sv
// window comparator on the upper eight result bits
`timescale 1ns/1ps
`default_nettype none
module adc_window_compare (
   input wire logic [9:0] result,
   input wire logic [7:0] upper_limit,
   input wire logic [7:0] lower_limit,
   input wire logic outside,
   output logic hit
);
   logic [7:0] result_upper_bits;

   // --------------------------------
   // match equation
   // --------------------------------
   // upper and lower carry no meaning of their own; swapping them changes nothing
   always_comb begin
      result_upper_bits = result[9:2];
      hit = outside ^ (upper_limit < result_upper_bits) ^ (lower_limit < result_upper_bits);
   end
endmodule
`default_nettype wire

// >>> testbench/sar_model.sv
// far-side model of the input mux, hold circuit and comparator
`timescale 1ns/1ps
`default_nettype none
module sar_model (
   input wire logic clk,
   input wire logic pwr,
   input wire logic [2:0] chan,
   input wire logic [9:0] level,
   output logic [9:0] code
);
   initial code = 10'h155;
   // unpowered, the code toggles so that a stale value never matches
   always @(posedge clk) begin
      code <= pwr ? level ^ {chan, 7'h00} : ~code;
   end
endmodule
`default_nettype wire

// >>> testbench/adc_seq_checker.sv
// port assertions for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
module adc_seq_checker (
   input wire logic SYS_CLK,
   input wire logic RST,
   input wire logic [7:0] REG_ADDR,
   input wire logic REG_WR,
   input wire logic [7:0] REG_WDATA,
   input wire logic START_PIN,
   input wire logic ANALOG_POWER,
   input wire logic SAMPLE,
   input wire logic CONVERT,
   input wire logic CONV_IRQ
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (RST);
   logic wr1, busy, pin_en, next_pin_en;
   // shadow of the pin trigger bit, which has no port of its own
   assign wr1 = REG_WR && REG_ADDR == adc_seq_pkg::ADDR_CONTROL_ONE;
   assign busy = SAMPLE || CONVERT;
   always_comb begin
      next_pin_en = wr1 ? REG_WDATA[adc_seq_pkg::BIT_PIN_TRIGGER] : pin_en;
   end
   always_ff @(posedge SYS_CLK) begin
      pin_en <= RST ? 1'b0 : next_pin_en;
   end
   // a control write or power loss excuses a phase cut short by abort
   sequence s_sample5; (SAMPLE || !ANALOG_POWER || $past(wr1))[*5]; endsequence
   sequence s_conv8; (CONVERT || !ANALOG_POWER || $past(wr1))[*8]; endsequence
   property p_reset; disable iff (1'b0) RST |=> !busy && !CONV_IRQ && !ANALOG_POWER; endproperty
   a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
   property p_abort; wr1 && !REG_WDATA[1] |-> ##[1:2] !busy; endproperty
   a_abort: assert property (p_abort) else $error("power off did not abort");
   property p_excl; !(SAMPLE && CONVERT); endproperty
   a_excl: assert property (p_excl) else $error("sample and convert overlap");
   property p_sample; $rose(SAMPLE) |-> s_sample5; endproperty
   a_sample: assert property (p_sample) else $error("sample phase too short");
   property p_conv; $rose(CONVERT) |-> s_conv8; endproperty
   a_conv: assert property (p_conv) else $error("approximation phase too short");
   property p_sw; wr1 && REG_WDATA[7] && ANALOG_POWER && !busy |-> ##[1:2] SAMPLE; endproperty
   a_sw: assert property (p_sw) else $error("software start ignored");
   property p_pin; $fell(START_PIN) && pin_en && ANALOG_POWER && !busy |-> ##[1:3] SAMPLE; endproperty
   a_pin: assert property (p_pin) else $error("pin edge did not start");
   property p_pin_off; $fell(START_PIN) && !pin_en && !busy && !REG_WR |=> !SAMPLE[*3]; endproperty
   a_pin_off: assert property (p_pin_off) else $error("disabled pin started");
   property p_irq; $rose(CONV_IRQ) |-> $past(CONVERT) || $past(CONVERT, 2) || $past(REG_WR) || $past(REG_WR, 2);
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt without cause");
endmodule
bind adc_sequencer adc_seq_checker chk_u (.SYS_CLK(SYS_CLK), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
   .REG_WDATA(REG_WDATA), .START_PIN(START_PIN), .ANALOG_POWER(ANALOG_POWER), .SAMPLE(SAMPLE),
   .CONVERT(CONVERT), .CONV_IRQ(CONV_IRQ));
`default_nettype wire

// >>> testbench/tb.sv
// self-checking bench for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk = 1'b0, rst = 1'b1, wr = 1'b0, pin = 1'b1;
   logic [7:0] addr = 8'h00, wdata = 8'h00, raddr = 8'h00;
   logic [9:0] level = 10'h000;
   logic [7:0] rdata, d;
   logic [9:0] sar, code;
   logic pwr, samp, conv, irq, hit;
   logic [2:0] chan;
   int n_errors = 0, tests_run = 0, cycles = 0, n, m, conv_cnt = 0;
   adc_sequencer dut_u (.SYS_CLK(clk), .RST(rst), .REG_ADDR(addr), .REG_WR(wr), .REG_WDATA(wdata),
      .REG_RD_ADDR(raddr), .REG_RDATA(rdata), .START_PIN(pin), .SAR_RESULT(sar), .ANALOG_POWER(pwr),
      .CHANNEL(chan), .SAMPLE(samp), .CONVERT(conv), .CONV_IRQ(irq));
   sar_model far_u (.clk(clk), .pwr(pwr), .chan(chan), .level(level), .code(sar));
   initial begin
      forever #25 clk = ~clk;
   end
   // ceiling far above the several hundred cycles the tests need
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         wrap_up();
      end
   end
   // approximation cycles counted a step after each edge, once outputs have settled
   always @(posedge clk) begin
      #1 if (conv === 1'b1) conv_cnt++;
   end
   task automatic wrap_up();
      if (n_errors == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // read data lags the address by one edge; a spare edge gives margin
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      raddr <= a;
      repeat (2) @(posedge clk);
      #1 d = rdata;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      rd(a);
      chk(d, exp);
   endtask
   task automatic wait_idle();
      d = 8'h80;
      for (int k = 0; k < 100 && d[7] !== 1'b0; k++) rd(8'hb2);
      chk(d[7], 1'b0);
   endtask
   // reset, then each channel, gating, repeat mode and pin start in turn
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      for (int a = 32'h0b2; a < 32'h0b9; a++) rd_chk(a[7:0], 8'h00);
      wr_reg(8'hb6, 8'h90);
      wr_reg(8'hb7, 8'h40);
      rd_chk(8'hb6, 8'h90);
      wr_reg(8'hb2, 8'h02);
      repeat (50) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         level = 10'h100 + i * 10'h071;
         code = level ^ {i[2:0], 7'h00};
         hit = i[0] ^ (8'h90 < code[9:2]) ^ (8'h40 < code[9:2]);
         wr_reg(8'hb3, {1'b0, i[2:0], 4'h0});
         wr_reg(8'hb2, {7'h41, i[0]});
         wr_reg(8'hb2, {7'h01, i[0]});
         rd(8'hb2);
         chk(d[7], 1'b1);
         wait_idle();
         rd_chk(8'hb2, {5'h08, hit, 1'b1, i[0]});
         chk(irq, 1'b1);
         rd_chk(8'hb4, code[9:2]);
         rd_chk(8'hb5, code[7:0]);
         wr_reg(8'hb3, {1'b1, i[2:0], 4'h0});
         rd_chk(8'hb4, {6'h00, code[9:8]});
         wr_reg(8'hb2, 8'h02);
      end
      level = 10'h200;
      wr_reg(8'hb3, 8'h00);
      wr_reg(8'hb2, 8'h8a);
      wait_idle();
      chk(irq, 1'b1);
      wr_reg(8'hb2, 8'h0a);
      level = 10'h000;
      wr_reg(8'hb2, 8'h8a);
      wait_idle();
      chk(irq, 1'b0);
      rd_chk(8'hb2, 8'h4a);
      wr_reg(8'hb2, 8'ha2);
      repeat (40) @(posedge clk);
      rd_chk(8'hb2, 8'he2);
      wr_reg(8'hb2, 8'h02);
      wait_idle();
      repeat (40) @(posedge clk);
      rd_chk(8'hb2, 8'h42);
      wr_reg(8'hb3, 8'h03);
      wr_reg(8'hb2, 8'h12);
      @(posedge clk);
      pin <= 1'b0;
      m = conv_cnt;
      n = 0;
      repeat (40) begin
         @(posedge clk);
         #1 if (samp === 1'b1) n++;
      end
      // the registered tick puts one idle cycle ahead of the first converter clock
      chk(n[9:0], 10'h015);
      rd(8'hb2);
      chk(d[7], 1'b1);
      wait_idle();
      n = conv_cnt - m;
      chk(n[9:0], 10'h02c);
      @(posedge clk);
      pin <= 1'b1;
      wr_reg(8'hb2, 8'h92);
      rd(8'hb2);
      chk(d[7], 1'b1);
      wr_reg(8'hb2, 8'h10);
      rd_chk(8'hb2, 8'h10);
      wr_reg(8'hb2, 8'h02);
      @(posedge clk);
      pin <= 1'b0;
      repeat (10) @(posedge clk);
      rd_chk(8'hb2, 8'h02);
      // a second reset while the sequencer is idle must clear the upper limit and control written earlier
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rd_chk(8'hb6, 8'h00);
      rd_chk(8'hb2, 8'h00);
      wrap_up();
   end
endmodule
`default_nettype wire
